/* osw_top.sv */
/*
  Frame logic of an eight-channel serial load switch: serial shift register
  with echo, pulse-count frame check, command latch, fault filter timer and
  supply shutdowns, with one channel module per output.
  Assumes serial clock, chip select, data and all fault indications come
  from outside the i_mclk domain; serial clock idles low, data is taken on
  its rising edge and the serial output changes on its falling edge.
*/
`timescale 1ns/1ps
`include "osw_regs.svh"

////////////////////////////////////////////////////////////////////////////////

module osw_top
  import osw_pkg::*;
#(
  parameter int unsigned FILT_CYC = `OSW_FILT_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_di,
  output logic o_do,
  output logic o_do_oe,
  input wire logic i_en,
  input wire logic i_vdd_ok,
  input wire logic i_vdd_uv,
  input wire logic i_load_supply_uv,
  input wire logic i_load_supply_ov,
  input wire logic [`OSW_NCH-1:0] i_thermal_limit_event,
  input wire logic [`OSW_NCH-1:0] i_overcurrent,
  input wire logic [`OSW_NCH-1:0] i_offstate_below_thr,
  output logic [`OSW_NCH-1:0] o_out_on,
  output logic [`OSW_NCH-1:0] o_ol_src_en
);

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisation

  localparam logic [`OSW_TMR_W-1:0] FILT_LAST = `OSW_TMR_W'(FILT_CYC - 1);

  logic [`OSW_SYNC_W-1:0] sy;
  logic sclk_s, csn_s, di_s, en_s, vddok_s, vdduv_s, pwruv_s, ov_s;
  logic [`OSW_NCH-1:0] thermal_s, ocur_s, cmp_s;

  osw_sync #(
    .W(`OSW_SYNC_W),
    .INIT(`OSW_SYNC_INIT)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_async({i_offstate_below_thr, i_overcurrent, i_thermal_limit_event,
              i_load_supply_ov, i_load_supply_uv, i_vdd_uv, i_vdd_ok, i_en,
              i_di, i_cs_n, i_sclk}),
    .o_sync(sy)
  );

  assign {cmp_s, ocur_s, thermal_s, ov_s, pwruv_s, vdduv_s, vddok_s, en_s,
          di_s, csn_s, sclk_s} = sy;

  // Sleep and undervoltage hold the logic in reset; release is a fresh start
  logic logic_rst;
  assign logic_rst = i_rst | ~en_s | ~vddok_s | vdduv_s | pwruv_s;

  //////////////////////////////////////////////////////////////////////////////
  // Frame logic

  osw_top_s st_q, st_d;
  logic cs_fall, cs_rise, sck_rise, sck_fall, frame_ok, rd_clr, eval;
  logic [`OSW_NCH-1:0] drive_v, fault_v;

  assign cs_fall = st_q.csn_d & ~csn_s;
  assign cs_rise = ~st_q.csn_d & csn_s;
  assign sck_rise = ~st_q.sclk_d & sclk_s & ~csn_s;
  assign sck_fall = st_q.sclk_d & ~sclk_s & ~csn_s;
  // Count saturates at 16 and then only tracks the remainder modulo 8
  assign frame_ok = st_q.clks[4] && (st_q.clks[2:0] == 3'h0);
  assign eval = (st_q.filt == OSW_FL_DONE);

  always_comb begin
    st_d = st_q;
    rd_clr = 1'b0;
    st_d.sclk_d = sclk_s;
    st_d.csn_d = csn_s;
    if (cs_fall) begin
      st_d.shreg = {`OSW_STAT_ZERO, fault_v};
      st_d.dout = 1'b0;
      st_d.clks = `OSW_CLKS_RST;
      rd_clr = 1'b1;
    end else if (sck_rise) begin
      st_d.shreg = {st_q.shreg[`OSW_WORD_W-2:0], di_s};
      if (st_q.clks[4]) begin
        st_d.clks = {2'b10, st_q.clks[2:0] + 3'h1};
      end else begin
        st_d.clks = st_q.clks + 5'h01;
      end
    end else if (sck_fall) begin
      st_d.dout = st_q.shreg[`OSW_WORD_W-1];
    end
    if (cs_rise) begin
      if (frame_ok) begin
        st_d.cmd = st_q.shreg;
      end
      st_d.filt = OSW_FL_WAIT;
      st_d.tmr = `OSW_TMR_RST;
    end else begin
      unique case (st_q.filt)
        OSW_FL_IDLE: begin
          st_d.tmr = `OSW_TMR_RST;
        end
        OSW_FL_WAIT: begin
          st_d.tmr = st_q.tmr + `OSW_TMR_W'(1);
          if (st_q.tmr == FILT_LAST) begin
            st_d.filt = OSW_FL_DONE;
          end
        end
        OSW_FL_DONE: begin
          st_d.tmr = st_q.tmr;
        end
        default: begin
          st_d.filt = OSW_FL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (logic_rst) begin
      st_q <= '0;
      st_q.csn_d <= 1'b1;
      st_q.cmd <= `OSW_CMD_RST;
    end else begin
      st_q <= st_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output channels

  for (genvar g = 0; g < `OSW_NCH; g++) begin : g_ch
    osw_chan_if cif();
    assign cif.cmd_on = st_q.cmd[`OSW_ON_LSB + g];
    assign cif.ol_en = st_q.cmd[`OSW_OLEN_LSB + g];
    assign cif.force_off = ov_s;
    assign cif.thermal_limit_event = thermal_s[g];
    assign cif.ocur = ocur_s[g];
    assign cif.cmp_low = cmp_s[g];
    assign cif.eval = eval;
    assign cif.rd_clr = rd_clr;
    assign drive_v[g] = cif.drive;
    assign fault_v[g] = cif.fault;
    osw_chan u_chan (
      .i_mclk(i_mclk),
      .i_rst(logic_rst),
      .ch(cif.chan)
    );
  end

  assign o_out_on = drive_v;
  assign o_ol_src_en = st_q.cmd[`OSW_OLEN_LSB +: `OSW_NCH];
  assign o_do = st_q.dout;
  // Released while deselected so several devices can share the return line
  assign o_do_oe = ~st_q.csn_d;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_accepted_end;
    cs_rise && frame_ok;
  endsequence

  sequence s_filter_expire;
    (st_q.filt == OSW_FL_WAIT) && (st_q.tmr == FILT_LAST) && !cs_rise;
  endsequence

  property p_cmd_latch;
    @(posedge i_mclk) disable iff (logic_rst)
      s_accepted_end |=> (st_q.cmd == $past(st_q.shreg));
  endproperty
  a_cmd_latch: assert property (p_cmd_latch) else $error("command not latched");

  property p_cmd_only_ok;
    @(posedge i_mclk) disable iff (logic_rst)
      $changed(st_q.cmd) |-> $past(cs_rise && frame_ok);
  endproperty
  a_cmd_only_ok: assert property (p_cmd_only_ok) else $error("command from bad frame");

  property p_bad_frame;
    @(posedge i_mclk) disable iff (logic_rst)
      (cs_rise && !frame_ok) |=> $stable(st_q.cmd);
  endproperty
  a_bad_frame: assert property (p_bad_frame) else $error("bad frame changed command");

  property p_status_hi;
    @(posedge i_mclk) disable iff (logic_rst)
      cs_fall |=> (st_q.shreg[`OSW_WORD_W-1:`OSW_NCH] == `OSW_STAT_ZERO) ##0 !o_do;
  endproperty
  a_status_hi: assert property (p_status_hi) else $error("status upper byte not zero");

  property p_shift;
    @(posedge i_mclk) disable iff (logic_rst)
      sck_rise && !cs_fall |=> (st_q.shreg == {$past(st_q.shreg[`OSW_WORD_W-2:0]), $past(di_s)});
  endproperty
  a_shift: assert property (p_shift) else $error("shift register not passing bits");

  property p_do_msb;
    @(posedge i_mclk) disable iff (logic_rst)
      sck_fall |=> (o_do == $past(st_q.shreg[`OSW_WORD_W-1])) ##1 $stable(o_do) || sck_fall;
  endproperty
  a_do_msb: assert property (p_do_msb) else $error("serial output not msb first");

  property p_ov_off;
    @(posedge i_mclk) disable iff (logic_rst)
      ov_s |=> (o_out_on == '0);
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("output on during overvoltage");

  property p_sleep_off;
    @(posedge i_mclk) disable iff (i_rst)
      (!en_s || !vddok_s || vdduv_s || pwruv_s) |=> (o_ol_src_en == '0) && (o_out_on == '0);
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("sleep left output or source on");

  property p_filt_start;
    @(posedge i_mclk) disable iff (logic_rst)
      cs_rise |=> !eval [*2];
  endproperty
  a_filt_start: assert property (p_filt_start) else $error("fault evaluated before filter");

  property p_filt_end;
    @(posedge i_mclk) disable iff (logic_rst)
      s_filter_expire |=> eval;
  endproperty
  a_filt_end: assert property (p_filt_end) else $error("filter did not expire");

  property p_oe_on;
    @(posedge i_mclk) disable iff (logic_rst)
      cs_fall |=> o_do_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("serial output not enabled in frame");

  property p_oe_off;
    @(posedge i_mclk) disable iff (logic_rst)
      cs_rise |=> !o_do_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("serial output not released");

  property p_count_step;
    @(posedge i_mclk) disable iff (logic_rst)
      (sck_rise && !cs_fall && !st_q.clks[4]) |=> (st_q.clks == $past(st_q.clks) + 5'h01);
  endproperty
  a_count_step: assert property (p_count_step) else $error("clock pulse not counted");

  property p_count_clear;
    @(posedge i_mclk) disable iff (logic_rst)
      cs_fall |=> (st_q.clks == `OSW_CLKS_RST);
  endproperty
  a_count_clear: assert property (p_count_clear) else $error("pulse count not cleared");

  property p_status_lo;
    @(posedge i_mclk) disable iff (logic_rst)
      cs_fall |=> (st_q.shreg[`OSW_NCH-1:0] == $past(fault_v));
  endproperty
  a_status_lo: assert property (p_status_lo) else $error("status lower byte not faults");

  property p_rst_off;
    @(posedge i_mclk)
      logic_rst |=> (o_ol_src_en == '0) && (o_out_on == '0);
  endproperty
  a_rst_off: assert property (p_rst_off) else $error("reset left output or source on");

  property p_filt_hold;
    @(posedge i_mclk) disable iff (logic_rst)
      (eval && !cs_rise) |=> eval;
  endproperty
  a_filt_hold: assert property (p_filt_hold) else $error("filter expiry not held");

  property p_ov_restore;
    @(posedge i_mclk) disable iff (logic_rst)
      $fell(ov_s) |=> (o_out_on == $past(st_q.cmd[`OSW_ON_LSB +: `OSW_NCH] & ~thermal_s));
  endproperty
  a_ov_restore: assert property (p_ov_restore) else $error("outputs not restored");

  property p_cmd_hold;
    @(posedge i_mclk) disable iff (logic_rst)
      !cs_rise |=> $stable(st_q.cmd);
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command changed outside frame end");

endmodule // osw_top

/* osw_regs.svh */
/*
  Constants of the eight-channel serial load switch: command word fields,
  frame length checking and the open-load fault filter time.
  Assumes inclusion by bare name from the package and the top module.
*/
`ifndef OSW_REGS_SVH
`define OSW_REGS_SVH

`define OSW_NCH 8
`define OSW_WORD_W 16
`define OSW_ON_LSB 0
`define OSW_OLEN_LSB 8
`define OSW_CMD_RST 16'h0000
`define OSW_STAT_ZERO 8'h00
`define OSW_CLKS_RST 5'h00
`define OSW_TMR_W 16
`define OSW_TMR_RST 16'h0000
`define OSW_SYNC_W 32
`define OSW_SYNC_INIT 32'h0000_0002
`define OSW_FILT_US 100
`define OSW_CLK_MHZ 200
`define OSW_FILT_CYC (`OSW_FILT_US * `OSW_CLK_MHZ)

`endif

/* osw_pkg.sv */
/*
  Types of the serial load switch: filter states and the state records of
  the top module and of one output channel.
  Assumes osw_regs.svh is on the include path.
*/
`include "osw_regs.svh"

package osw_pkg;

  typedef enum logic [1:0] {
    OSW_FL_IDLE = 2'b00,
    OSW_FL_WAIT = 2'b01,
    OSW_FL_DONE = 2'b10
  } osw_filt_e;

  typedef struct packed {
    logic [`OSW_WORD_W-1:0] shreg;
    logic [4:0] clks;
    logic [`OSW_WORD_W-1:0] cmd;
    logic dout;
    logic sclk_d;
    logic csn_d;
    osw_filt_e filt;
    logic [`OSW_TMR_W-1:0] tmr;
  } osw_top_s;

  typedef struct packed {
    logic ol_flag;
    logic drive;
  } osw_chan_s;

endpackage

/* osw_chan_if.sv */
/*
  Interface between the frame logic and one output channel.
  Assumes one instance per channel, driven on the single module clock.
*/
`timescale 1ns/1ps

interface osw_chan_if;
  logic cmd_on;
  logic ol_en;
  logic force_off;
  logic thermal_limit_event;
  logic ocur;
  logic cmp_low;
  logic eval;
  logic rd_clr;
  logic drive;
  logic fault;

  modport top (
    output cmd_on, ol_en, force_off, thermal_limit_event, ocur, cmp_low, eval, rd_clr,
    input drive, fault
  );
  modport chan (
    input cmd_on, ol_en, force_off, thermal_limit_event, ocur, cmp_low, eval, rd_clr,
    output drive, fault
  );
endinterface

/* osw_sync.sv */
/*
  Three-stage input synchroniser with agreement filter.
  Assumes inputs arrive from outside the module clock domain.
*/
`timescale 1ns/1ps

module osw_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] val;
  } osw_sync_s;

  osw_sync_s st_q, st_d;

  // Stage one feeds stage two only; the filter looks at stages two and three
  always_comb begin
    st_d = st_q;
    st_d.s1 = i_async;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int b = 0; b < W; b++) begin
      if (st_q.s2[b] == st_q.s3[b]) begin
        st_d.val[b] = st_q.s3[b];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_q <= {INIT, INIT, INIT, INIT};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_sync = st_q.val;
endmodule // osw_sync

/* osw_chan.sv */
/*
  One output channel: drive gating and open-load fault latch.
  Assumes all inputs are already synchronous to i_mclk.
*/
`timescale 1ns/1ps

module osw_chan
  import osw_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  osw_chan_if.chan ch
);
  osw_chan_s st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.drive = ch.cmd_on & ~ch.thermal_limit_event & ~ch.force_off;
    if (ch.rd_clr) begin
      st_d.ol_flag = 1'b0;
    end
    // Set beats the read clear so a fault in the read cycle survives
    if (ch.eval && !ch.cmd_on && ch.ol_en && ch.cmp_low) begin
      st_d.ol_flag = 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign ch.drive = st_q.drive;
  assign ch.fault = st_q.ol_flag | ch.thermal_limit_event | ch.ocur;

  property p_therm_off;
    @(posedge i_mclk) disable iff (i_rst) ch.thermal_limit_event |=> !ch.drive;
  endproperty
  a_therm_off: assert property (p_therm_off) else $error("output on during thermal limit");

  property p_auto_on;
    @(posedge i_mclk) disable iff (i_rst)
      (ch.cmd_on && !ch.thermal_limit_event && !ch.force_off) |=> ch.drive;
  endproperty
  a_auto_on: assert property (p_auto_on) else $error("output not restored");

  property p_ol_hold;
    @(posedge i_mclk) disable iff (i_rst)
      (st_q.ol_flag && !ch.rd_clr) |=> (st_q.ol_flag && ch.fault);
  endproperty
  a_ol_hold: assert property (p_ol_hold) else $error("open-load flag lost before read");

  property p_ol_set;
    @(posedge i_mclk) disable iff (i_rst)
      (ch.eval && !ch.cmd_on && ch.ol_en && ch.cmp_low) |=> ch.fault;
  endproperty
  a_ol_set: assert property (p_ol_set) else $error("open load not flagged");
endmodule // osw_chan

/* osw_host.sv */
/*
  Host model: serial bus master for the load switch, 64 ns serial clock.
  Assumes the bench calls xfer with at most 32 bits and spaces frames itself.
*/
`timescale 1ns/1ps

module osw_host (
  input wire logic i_do,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_di
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_di = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////

  // Clock stands still between frames; released data line shows the inverse
  // so a stale bit can never pass for a good one
  task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = '0;
    o_cs_n <= 1'b0;
    #96;
    for (int i = n - 1; i >= 0; i--) begin
      o_di <= tx[i];
      #32;
      o_sclk <= 1'b1;
      rx = {rx[30:0], i_do};
      #32;
      o_sclk <= 1'b0;
    end
    #64;
    o_cs_n <= 1'b1;
    o_di <= ~o_di;
    #50;
  endtask
endmodule // osw_host

/* osw_top_tb.sv */
/*
  Self-checking bench of the serial load switch with a host model.
  Assumes osw_regs.svh on the include path and a short filter parameter.
*/
`timescale 1ns/1ps
`include "osw_regs.svh"

module osw_top_tb;
  localparam int FILT = 20;
  logic i_mclk, i_rst, en, vdd_ok, vdd_uv, ls_uv, ls_ov;
  logic [7:0] therm, oc, olow, out_on, src_en;
  logic sclk, cs_n, di, do_s, do_oe, do_line;
  logic [15:0] cmd_exp;
  logic [31:0] rx, tx, msk;
  int seed, n, err_total, num_checks;
  int lens[8] = '{16, 24, 32, 8, 15, 17, 20, 31};

  osw_top #(.FILT_CYC(FILT)) dut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_di(di),
    .o_do(do_s), .o_do_oe(do_oe), .i_en(en), .i_vdd_ok(vdd_ok),
    .i_vdd_uv(vdd_uv), .i_load_supply_uv(ls_uv), .i_load_supply_ov(ls_ov),
    .i_thermal_limit_event(therm), .i_overcurrent(oc),
    .i_offstate_below_thr(olow), .o_out_on(out_on), .o_ol_src_en(src_en)
  );

  // A deselected return line shows the inverse, so a missing enable shows up as bad data
  assign do_line = do_oe ? do_s : ~do_s;

  osw_host host (.i_do(do_line), .o_sclk(sclk), .o_cs_n(cs_n), .o_di(di));

  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  //////////////////////////////////////////////////////////////////////////////

  function automatic logic [7:0] exp_on(input logic [15:0] c, input logic [7:0] t,
                                        input logic ov);
    return c[7:0] & ~t & {8{~ov}};
  endfunction

  function automatic bit len_ok(input int len);
    return len >= 16 && (len - 16) % 8 == 0;
  endfunction

  task automatic settle();
    repeat (12) @(posedge i_mclk);
  endtask

  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_out();
    settle();
    chk_val("out_on", 32'(exp_on(cmd_exp, therm, ls_ov)), 32'(out_on));
    chk_val("src_en", 32'(cmd_exp[15:8]), 32'(src_en));
    chk_val("do_oe idle", 32'h0, 32'(do_oe));
  endtask

  // Only frames of an accepted length move the expected command
  task automatic frame(input int len, input logic [31:0] t);
    host.xfer(len, t, rx);
    if (len_ok(len)) cmd_exp = t[15:0];
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////

  initial begin
    #400000;
    err_total++;
    conclude();
  end

  initial begin
    seed = 32'hcc00;
    err_total = 0;
    num_checks = 0;
    cmd_exp = '0;
    i_rst = 1'b1;
    en = 1'b1;
    vdd_ok = 1'b1;
    vdd_uv = 1'b0;
    ls_uv = 1'b0;
    ls_ov = 1'b0;
    therm = 8'h00;
    oc = 8'h00;
    olow = 8'h00;
    repeat (8) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (20) @(posedge i_mclk);
    chk_out();
    @(posedge i_mclk) oc <= 8'h21;
    settle();
    frame(32, 32'h5a3c_00a5);
    chk_val("integrity", {8'h00, 8'h21, 16'h5a3c}, rx);
    chk_out();
    for (int k = 0; k < 24; k++) begin
      n = lens[k % 8];
      tx = $random(seed);
      @(posedge i_mclk) oc <= 8'($random(seed));
      settle();
      frame(n, tx);
      if (n >= 16) chk_val("status", {8'h00, oc}, (rx >> (n - 16)) & 32'hffff);
      if (n > 16) begin
        msk = (32'h1 << (n - 16)) - 32'h1;
        chk_val("echo", (tx >> 16) & msk, rx & msk);
      end
      chk_out();
    end
    frame(16, 32'h00ff);
    @(posedge i_mclk) begin
      therm <= 8'h11;
      oc <= 8'h00;
    end
    chk_out();
    frame(16, 32'h00ff);
    chk_val("thermal status", 32'h0011, rx);
    @(posedge i_mclk) therm <= 8'h00;
    chk_out();
    @(posedge i_mclk) ls_ov <= 1'b1;
    chk_out();
    @(posedge i_mclk) ls_ov <= 1'b0;
    chk_out();
    // A comparator blip inside the filter time must not latch
    frame(16, 32'hff00);
    @(posedge i_mclk) olow <= 8'h81;
    repeat (4) @(posedge i_mclk);
    olow <= 8'h00;
    repeat (40) @(posedge i_mclk);
    frame(16, 32'hff00);
    chk_val("filtered blip", 32'h0000, rx);
    @(posedge i_mclk) olow <= 8'h81;
    repeat (40) @(posedge i_mclk);
    olow <= 8'h00;
    settle();
    frame(16, 32'hff00);
    chk_val("open load latched", 32'h0081, rx);
    repeat (40) @(posedge i_mclk);
    frame(16, 32'hff00);
    chk_val("open load read", 32'h0000, rx);
    for (int k = 0; k < 4; k++) begin
      frame(16, 32'hffff);
      chk_out();
      @(posedge i_mclk) begin
        en <= (k != 0);
        vdd_ok <= (k != 1);
        vdd_uv <= (k == 2);
        ls_uv <= (k == 3);
      end
      cmd_exp = '0;
      chk_out();
      @(posedge i_mclk) begin
        en <= 1'b1;
        vdd_ok <= 1'b1;
        vdd_uv <= 1'b0;
        ls_uv <= 1'b0;
      end
      repeat (20) @(posedge i_mclk);
      chk_out();
    end
    conclude();
  end
endmodule // osw_top_tb
